/* File: switch_ctrl_pkg.sv */
// constants shared by the global control register block and the storm limiter
package switch_ctrl_pkg;

    localparam int          NUM_PORTS      = 5;

    // register offsets
    localparam logic [7:0]  OFS_FWD_OPT    = 8'h05;
    localparam logic [7:0]  OFS_LINK_STORM = 8'h06;
    localparam logic [7:0]  OFS_STORM_LO   = 8'h07;
    localparam logic [7:0]  OFS_TEST_A     = 8'h08;
    localparam logic [7:0]  OFS_TEST_B     = 8'h09;

    // forwarding_options fields
    localparam int          FWD_PRETAG_BIT = 4;
    localparam int          FWD_TAGMSK_BIT = 1;
    localparam int          FWD_SNIFF_BIT  = 0;

    // port5_link_and_storm_high fields
    localparam int          LNK_BP_BIT     = 7;
    localparam int          LNK_HDX_BIT    = 6;
    localparam int          LNK_FC_BIT     = 5;
    localparam int          LNK_SPD_BIT    = 4;
    localparam int          LNK_NULL_BIT   = 3;
    localparam int          LNK_STORM_MSB  = 2;

    // values after reset
    localparam logic [7:0]  FWD_OPT_RST    = 8'h00;
    localparam logic        LNK_BP_RST     = 1'b0;
    localparam logic        LNK_NULL_RST   = 1'b0;
    localparam logic [2:0]  STORM_HI_RST   = 3'h0;
    localparam logic [7:0]  STORM_LO_RST   = 8'h4a;
    localparam logic [7:0]  TEST_A_VAL     = 8'h00;
    localparam logic [7:0]  TEST_B_VAL     = 8'h4c;

    // storm measurement periods
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          PERIOD_FAST_MS = 50;
    localparam int          PERIOD_SLOW_MS = 500;
    localparam int          FAST_CYCLES    = (CLK_HZ / 1000) * PERIOD_FAST_MS;
    localparam int          SLOW_CYCLES    = (CLK_HZ / 1000) * PERIOD_SLOW_MS;
    localparam int          PERIOD_W       = 23;

    // one-hot port select; indexes beyond the last port give zero
    function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [2:0] idx);
        logic [NUM_PORTS-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (idx == 3'(i))
                m[i] = 1'b1;
        end
        return m;
    endfunction : port_onehot

endpackage : switch_ctrl_pkg

/* File: switch_storm_limiter.sv */
// per-port broadcast storm limiter counting 64-byte blocks per period
module switch_storm_limiter
    import switch_ctrl_pkg::*;
#(
    parameter int FAST_CYC = switch_ctrl_pkg::FAST_CYCLES,
    parameter int SLOW_CYC = switch_ctrl_pkg::SLOW_CYCLES
)
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // configuration
    input  wire logic [10:0]           storm_limit,
    input  wire logic [switch_ctrl_pkg::NUM_PORTS-1:0] port_is_10m,
    // block stream
    input  wire logic                  blk_valid,
    input  wire logic [2:0]            blk_port,
    output logic                       blk_drop
);
    import switch_ctrl_pkg::*;

    logic [PERIOD_W-1:0]  fast_r;
    logic [PERIOD_W-1:0]  fast_nxt;
    logic [PERIOD_W-1:0]  slow_r;
    logic [PERIOD_W-1:0]  slow_nxt;
    logic [10:0]          cnt_r   [NUM_PORTS];
    logic [10:0]          cnt_nxt [NUM_PORTS];
    logic                 fast_tick;
    logic                 slow_tick;
    logic [NUM_PORTS-1:0] sel;
    logic                 over;

    always_comb
    begin
        fast_tick = (fast_r == PERIOD_W'(FAST_CYC - 1));
        slow_tick = (slow_r == PERIOD_W'(SLOW_CYC - 1));
        fast_nxt  = fast_tick ? '0 : fast_r + 1'b1;
        slow_nxt  = slow_tick ? '0 : slow_r + 1'b1;
        sel       = port_onehot(blk_port);
        over      = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (sel[i] && cnt_r[i] >= storm_limit)
                over = 1'b1;
        end
        blk_drop  = blk_valid && over;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            cnt_nxt[i] = cnt_r[i];
            if (port_is_10m[i] ? slow_tick : fast_tick)
                cnt_nxt[i] = '0;
            if (blk_valid && sel[i] && !over)
                cnt_nxt[i] = cnt_nxt[i] + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            fast_r <= '0;
            slow_r <= '0;
            for (int i = 0; i < NUM_PORTS; i++)
                cnt_r[i] <= '0;
        end
        else
        begin
            fast_r <= fast_nxt;
            slow_r <= slow_nxt;
            for (int i = 0; i < NUM_PORTS; i++)
                cnt_r[i] <= cnt_nxt[i];
        end
    end

endmodule : switch_storm_limiter

/* File: switch_global_control_regs.sv */
// global control registers for the cpu port link, forwarding options and storm rate
//
// Functional notes
// - pre-tag set: frames out on the cpu port carry source port number first.
// - tag-mask mode: low five VID bits become the forwarding port mask.
// - tag-mask applies only while 802.1q VLAN mode is off.
// - sniff select one: mirror only when source and destination both match.
// - sniff select zero: mirror when source or destination matches.
// - back pressure bit enables half-duplex back pressure on the cpu port.
// - duplex bit one gives half duplex, zero full duplex.
// - flow control bit enables full-duplex flow control on the cpu port.
// - speed bit one gives 10Mbps, zero gives 100Mbps.
// - duplex, flow control and speed load from strap pins at reset.
// - null VID replacement swaps a zero VID for the port default VID.
// - storm rate is eleven bits split over two registers.
// - storm period is 50ms at 100 megabit, 500ms at 10 megabit.
// - storm rate resets to 0x4a low, zero high bits.
module switch_global_control_regs
    import switch_ctrl_pkg::*;
#(
    parameter int FAST_CYC = switch_ctrl_pkg::FAST_CYCLES,
    parameter int SLOW_CYC = switch_ctrl_pkg::SLOW_CYCLES
)
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // strap pins
    input  wire logic        speed_strap_pin,
    input  wire logic        duplex_strap_pin,
    input  wire logic        flow_control_strap_pin,
    // register access port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    // switch_side_cpu_port_link settings
    output logic             cpu_link_backpressure,
    output logic             cpu_link_half_duplex,
    output logic             cpu_link_flow_control,
    output logic             cpu_link_speed_10m,
    // frame start toward the cpu port
    input  wire logic        cpu_tx_start,
    input  wire logic [2:0]  cpu_tx_src_port,
    output logic             pretag_valid,
    output logic [2:0]       pretag_port,
    // packet descriptor in
    input  wire logic        vlan_mode_on,
    input  wire logic [4:0]  rx_sniff_ports,
    input  wire logic [4:0]  tx_sniff_ports,
    input  wire logic        pkt_valid,
    input  wire logic [2:0]  pkt_src_port,
    input  wire logic [4:0]  pkt_dst_mask,
    input  wire logic [11:0] pkt_vid,
    input  wire logic [11:0] port_default_vid,
    // packet descriptor out
    output logic             fwd_valid,
    output logic [4:0]       fwd_mask,
    output logic [11:0]      fwd_vid,
    output logic             fwd_mirror,
    // broadcast block stream
    input  wire logic [4:0]  port_is_10m,
    input  wire logic        bcast_blk_valid,
    input  wire logic [2:0]  bcast_blk_port,
    output logic             bcast_blk_drop
);
    import switch_ctrl_pkg::*;

    // register state
    logic        pretag_en_r;
    logic        pretag_en_nxt;
    logic        tagmask_en_r;
    logic        tagmask_en_nxt;
    logic        sniff_and_r;
    logic        sniff_and_nxt;
    logic        bp_en_r;
    logic        bp_en_nxt;
    logic        half_dpx_r;
    logic        half_dpx_nxt;
    logic        fc_en_r;
    logic        fc_en_nxt;
    logic        speed_10_r;
    logic        speed_10_nxt;
    logic        null_repl_r;
    logic        null_repl_nxt;
    logic [2:0]  storm_hi_r;
    logic [2:0]  storm_hi_nxt;
    logic [7:0]  storm_lo_r;
    logic [7:0]  storm_lo_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    // datapath state
    logic        pretag_valid_r;
    logic        pretag_valid_nxt;
    logic [2:0]  pretag_port_r;
    logic [2:0]  pretag_port_nxt;
    logic        fwd_valid_r;
    logic        fwd_valid_nxt;
    logic [4:0]  fwd_mask_r;
    logic [4:0]  fwd_mask_nxt;
    logic [11:0] fwd_vid_r;
    logic [11:0] fwd_vid_nxt;
    logic        fwd_mirror_r;
    logic        fwd_mirror_nxt;

    logic        mask_active;
    logic        src_hit;
    logic        dst_hit;
    logic [10:0] storm_limit;

    // register writes and reads
    always_comb
    begin
        pretag_en_nxt  = pretag_en_r;
        tagmask_en_nxt = tagmask_en_r;
        sniff_and_nxt  = sniff_and_r;
        bp_en_nxt      = bp_en_r;
        half_dpx_nxt   = half_dpx_r;
        fc_en_nxt      = fc_en_r;
        speed_10_nxt   = speed_10_r;
        null_repl_nxt  = null_repl_r;
        storm_hi_nxt   = storm_hi_r;
        storm_lo_nxt   = storm_lo_r;
        rdata_nxt      = rdata_r;
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_FWD_OPT:
                begin
                    pretag_en_nxt  = reg_wdata[FWD_PRETAG_BIT];
                    tagmask_en_nxt = reg_wdata[FWD_TAGMSK_BIT];
                    sniff_and_nxt  = reg_wdata[FWD_SNIFF_BIT];
                end
                OFS_LINK_STORM:
                begin
                    bp_en_nxt      = reg_wdata[LNK_BP_BIT];
                    half_dpx_nxt   = reg_wdata[LNK_HDX_BIT];
                    fc_en_nxt      = reg_wdata[LNK_FC_BIT];
                    speed_10_nxt   = reg_wdata[LNK_SPD_BIT];
                    null_repl_nxt  = reg_wdata[LNK_NULL_BIT];
                    storm_hi_nxt   = reg_wdata[LNK_STORM_MSB:0];
                end
                OFS_STORM_LO:
                    storm_lo_nxt   = reg_wdata;
                // factory test and unmapped offsets ignore writes
                default:
                    storm_lo_nxt   = storm_lo_r;
            endcase
        end
        // a read in the cycle of a write returns the old value
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_FWD_OPT:
                begin
                    rdata_nxt                 = 8'h00;
                    rdata_nxt[FWD_PRETAG_BIT] = pretag_en_r;
                    rdata_nxt[FWD_TAGMSK_BIT] = tagmask_en_r;
                    rdata_nxt[FWD_SNIFF_BIT]  = sniff_and_r;
                end
                OFS_LINK_STORM:
                begin
                    rdata_nxt                   = 8'h00;
                    rdata_nxt[LNK_BP_BIT]       = bp_en_r;
                    rdata_nxt[LNK_HDX_BIT]      = half_dpx_r;
                    rdata_nxt[LNK_FC_BIT]       = fc_en_r;
                    rdata_nxt[LNK_SPD_BIT]      = speed_10_r;
                    rdata_nxt[LNK_NULL_BIT]     = null_repl_r;
                    rdata_nxt[LNK_STORM_MSB:0]  = storm_hi_r;
                end
                OFS_STORM_LO:
                    rdata_nxt = storm_lo_r;
                OFS_TEST_A:
                    rdata_nxt = TEST_A_VAL;
                OFS_TEST_B:
                    rdata_nxt = TEST_B_VAL;
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pretag_en_r  <= FWD_OPT_RST[FWD_PRETAG_BIT];
            tagmask_en_r <= FWD_OPT_RST[FWD_TAGMSK_BIT];
            sniff_and_r  <= FWD_OPT_RST[FWD_SNIFF_BIT];
            bp_en_r      <= LNK_BP_RST;
            // straps are sampled on every clock edge while reset is low; the last sample stays
            half_dpx_r   <= duplex_strap_pin;
            fc_en_r      <= flow_control_strap_pin;
            speed_10_r   <= speed_strap_pin;
            null_repl_r  <= LNK_NULL_RST;
            storm_hi_r   <= STORM_HI_RST;
            storm_lo_r   <= STORM_LO_RST;
            rdata_r      <= 8'h00;
        end
        else
        begin
            pretag_en_r  <= pretag_en_nxt;
            tagmask_en_r <= tagmask_en_nxt;
            sniff_and_r  <= sniff_and_nxt;
            bp_en_r      <= bp_en_nxt;
            half_dpx_r   <= half_dpx_nxt;
            fc_en_r      <= fc_en_nxt;
            speed_10_r   <= speed_10_nxt;
            null_repl_r  <= null_repl_nxt;
            storm_hi_r   <= storm_hi_nxt;
            storm_lo_r   <= storm_lo_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    // packet options: pre-tag, tag mask, null VID, sniff
    always_comb
    begin
        // pre-tag is a pulse; the cpu port logic inserts the tag itself
        pretag_valid_nxt = cpu_tx_start && pretag_en_r;
        pretag_port_nxt  = pretag_valid_nxt ? cpu_tx_src_port : pretag_port_r;
        // VLAN mode overrides the tag mask
        mask_active      = tagmask_en_r && !vlan_mode_on;
        src_hit          = |(port_onehot(pkt_src_port) & rx_sniff_ports);
        // destination match uses the lookup mask, not the tag mask
        dst_hit          = |(pkt_dst_mask & tx_sniff_ports);
        fwd_valid_nxt    = pkt_valid;
        fwd_mask_nxt     = fwd_mask_r;
        fwd_vid_nxt      = fwd_vid_r;
        fwd_mirror_nxt   = 1'b0;
        if (pkt_valid)
        begin
            fwd_mask_nxt = mask_active ? pkt_vid[4:0] : pkt_dst_mask;
            if (null_repl_r && pkt_vid == 12'h000)
                fwd_vid_nxt = port_default_vid;
            else
                fwd_vid_nxt = pkt_vid;
            if (sniff_and_r)
                fwd_mirror_nxt = src_hit && dst_hit;
            else
                fwd_mirror_nxt = src_hit || dst_hit;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pretag_valid_r <= 1'b0;
            pretag_port_r  <= 3'h0;
            fwd_valid_r    <= 1'b0;
            fwd_mask_r     <= 5'h00;
            fwd_vid_r      <= 12'h000;
            fwd_mirror_r   <= 1'b0;
        end
        else
        begin
            pretag_valid_r <= pretag_valid_nxt;
            pretag_port_r  <= pretag_port_nxt;
            fwd_valid_r    <= fwd_valid_nxt;
            fwd_mask_r     <= fwd_mask_nxt;
            fwd_vid_r      <= fwd_vid_nxt;
            fwd_mirror_r   <= fwd_mirror_nxt;
        end
    end

    // broadcast storm limiting
    // limit 0 drops every block of ports 0-4; ports beyond the last are never counted or dropped
    assign storm_limit = {storm_hi_r, storm_lo_r};

    switch_storm_limiter
    #(
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
    )
    u_storm
    (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .storm_limit (storm_limit),
        .port_is_10m (port_is_10m),
        .blk_valid   (bcast_blk_valid),
        .blk_port    (bcast_blk_port),
        .blk_drop    (bcast_blk_drop)
    );

    // outputs
    // link settings and descriptor results come straight from flip-flops
    assign reg_rdata             = rdata_r;
    assign cpu_link_backpressure = bp_en_r;
    assign cpu_link_half_duplex  = half_dpx_r;
    assign cpu_link_flow_control = fc_en_r;
    assign cpu_link_speed_10m    = speed_10_r;
    assign pretag_valid          = pretag_valid_r;
    assign pretag_port           = pretag_port_r;
    assign fwd_valid             = fwd_valid_r;
    assign fwd_mask              = fwd_mask_r;
    assign fwd_vid               = fwd_vid_r;
    assign fwd_mirror            = fwd_mirror_r;

endmodule : switch_global_control_regs

/* File: switch_global_control_regs_properties.sv */
// port checker for the global control register block
module switch_ctrl_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // cpu port link
    input wire logic        cpu_link_backpressure,
    input wire logic        cpu_link_half_duplex,
    input wire logic        cpu_link_flow_control,
    input wire logic        cpu_link_speed_10m,
    // pre-tag
    input wire logic        cpu_tx_start,
    input wire logic [2:0]  cpu_tx_src_port,
    input wire logic        pretag_valid,
    input wire logic [2:0]  pretag_port,
    // descriptor
    input wire logic        vlan_mode_on,
    input wire logic [4:0]  rx_sniff_ports,
    input wire logic [4:0]  tx_sniff_ports,
    input wire logic        pkt_valid,
    input wire logic [2:0]  pkt_src_port,
    input wire logic [4:0]  pkt_dst_mask,
    input wire logic [11:0] pkt_vid,
    input wire logic        fwd_valid,
    input wire logic [4:0]  fwd_mask,
    input wire logic [11:0] fwd_vid,
    input wire logic        fwd_mirror,
    // storm
    input wire logic        bcast_blk_valid,
    input wire logic [2:0]  bcast_blk_port,
    input wire logic        bcast_blk_drop
);
    logic src_hit;
    logic dst_hit;
    assign src_hit = (pkt_src_port < 3'h5) && rx_sniff_ports[pkt_src_port];
    assign dst_hit = |(pkt_dst_mask & tx_sniff_ports);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_lone_pkt;
        pkt_valid ##1 !pkt_valid;
    endsequence
    sequence s_fwd_pulse;
        fwd_valid ##1 !fwd_valid;
    endsequence
    sequence s_tx_start;
        cpu_tx_start ##1 pretag_valid;
    endsequence

    property p_fwd_pulse;
        s_lone_pkt |-> s_fwd_pulse;
    endproperty
    property p_pretag_port;
        s_tx_start |-> pretag_port == $past(cpu_tx_src_port);
    endproperty
    property p_mirror_idle;
        !fwd_valid |-> !fwd_mirror;
    endproperty
    property p_vid_keep;
        pkt_valid && pkt_vid != 12'h000 |=> fwd_vid == $past(pkt_vid);
    endproperty
    property p_mask_vlan;
        pkt_valid && vlan_mode_on |=> fwd_mask == $past(pkt_dst_mask);
    endproperty
    property p_mirror_both;
        pkt_valid && src_hit && dst_hit |=> fwd_valid && fwd_mirror;
    endproperty
    property p_mirror_none;
        pkt_valid && !src_hit && !dst_hit |=> fwd_valid && !fwd_mirror;
    endproperty
    property p_rdata_hold;
        !$past(reg_rd) |-> $stable(reg_rdata);
    endproperty
    property p_link_hold;
        !($past(reg_wr) && $past(reg_addr) == 8'h06) |->
            $stable({cpu_link_backpressure, cpu_link_half_duplex, cpu_link_flow_control, cpu_link_speed_10m});
    endproperty
    property p_blk_badport;
        bcast_blk_valid && bcast_blk_port > 3'h4 |-> !bcast_blk_drop;
    endproperty

    a_fwd_pulse: assert property (p_fwd_pulse) else $error("descriptor answer not a single pulse");
    a_pretag_port: assert property (p_pretag_port) else $error("pre-tag port wrong");
    a_mirror_idle: assert property (p_mirror_idle) else $error("mirror without descriptor");
    a_vid_keep: assert property (p_vid_keep) else $error("non-null vid altered");
    a_mask_vlan: assert property (p_mask_vlan) else $error("tag mask used in vlan mode");
    a_mirror_both: assert property (p_mirror_both) else $error("double match not mirrored");
    a_mirror_none: assert property (p_mirror_none) else $error("mirror without match");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    a_link_hold: assert property (p_link_hold) else $error("link setting moved without write");
    a_blk_badport: assert property (p_blk_badport) else $error("block of bad port dropped");
endmodule : switch_ctrl_checker

bind switch_global_control_regs switch_ctrl_checker chk (
    .mclk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .cpu_link_backpressure, .cpu_link_half_duplex,
    .cpu_link_flow_control, .cpu_link_speed_10m, .cpu_tx_start, .cpu_tx_src_port, .pretag_valid, .pretag_port,
    .vlan_mode_on, .rx_sniff_ports, .tx_sniff_ports, .pkt_valid, .pkt_src_port, .pkt_dst_mask, .pkt_vid,
    .fwd_valid, .fwd_mask, .fwd_vid, .fwd_mirror, .bcast_blk_valid, .bcast_blk_port, .bcast_blk_drop
);

/* File: tb_switch_global_control_regs.sv */
// self-checking bench for the global control register block
module tb_switch_global_control_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        reset_n, speed_strap_pin, duplex_strap_pin, flow_control_strap_pin;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, cpu_tx_start = 1'b0, pretag_valid;
    logic        cpu_link_backpressure, cpu_link_half_duplex, cpu_link_flow_control, cpu_link_speed_10m;
    logic [2:0]  cpu_tx_src_port = 3'h0, pretag_port, pkt_src_port = 3'h0, bcast_blk_port = 3'h0;
    logic        vlan_mode_on = 1'b0, pkt_valid = 1'b0, fwd_valid, fwd_mirror;
    logic        bcast_blk_valid = 1'b0, bcast_blk_drop;
    logic [4:0]  rx_sniff_ports = 5'h01, tx_sniff_ports = 5'h04, pkt_dst_mask = 5'h00, fwd_mask;
    logic [4:0]  port_is_10m = 5'h02;
    logic [11:0] pkt_vid = 12'h000, port_default_vid = 12'habc, fwd_vid;
    logic [7:0]  ra [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0b};
    logic [7:0]  re [6] = '{8'h00, 8'h30, 8'h4a, 8'h00, 8'h4c, 8'h00};
    int          num_errors = 0;
    int          checked = 0;

    switch_global_control_regs #(.FAST_CYC(20), .SLOW_CYC(50)) dut (
        .mclk, .reset_n, .speed_strap_pin, .duplex_strap_pin, .flow_control_strap_pin,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cpu_link_backpressure, .cpu_link_half_duplex,
        .cpu_link_flow_control, .cpu_link_speed_10m, .cpu_tx_start, .cpu_tx_src_port, .pretag_valid, .pretag_port,
        .vlan_mode_on, .rx_sniff_ports, .tx_sniff_ports, .pkt_valid, .pkt_src_port, .pkt_dst_mask, .pkt_vid,
        .port_default_vid, .fwd_valid, .fwd_mask, .fwd_vid, .fwd_mirror, .port_is_10m, .bcast_blk_valid,
        .bcast_blk_port, .bcast_blk_drop
    );

    always #50 mclk = ~mclk;

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic logic [3:0] link_bits();
        return {cpu_link_backpressure, cpu_link_half_duplex, cpu_link_flow_control, cpu_link_speed_10m};
    endfunction : link_bits

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick

    // straps flip after release: they must only count while reset is low
    task automatic do_reset(input logic spd, input logic dup, input logic fc);
        {speed_strap_pin, duplex_strap_pin, flow_control_strap_pin} = {spd, dup, fc};
        reset_n = 1'b0;
        repeat (8) tick;
        reset_n = 1'b1;
        {speed_strap_pin, duplex_strap_pin, flow_control_strap_pin} = ~{spd, dup, fc};
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        tick;
        {reg_wdata, reg_wr} = {~d, 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick;
        {reg_addr, reg_rd} = {a, 1'b1};
        tick;
        reg_rd = 1'b0;
        cmp($sformatf("rdata %h", a), exp, reg_rdata);
    endtask : rd

    task automatic tx(input logic [2:0] src, input logic ev);
        tick;
        {cpu_tx_start, cpu_tx_src_port} = {1'b1, src};
        tick;
        cpu_tx_start = 1'b0;
        cmp("pretag_valid", ev, pretag_valid);
        if (ev)
            cmp("pretag_port", src, pretag_port);
    endtask : tx

    task automatic pkt(input logic [2:0] src, input logic [4:0] dst, input logic [11:0] vid, input logic vlan,
                       input logic [4:0] em, input logic [11:0] ev, input logic emir);
        tick;
        {pkt_src_port, pkt_dst_mask, pkt_vid, vlan_mode_on, pkt_valid} = {src, dst, vid, vlan, 1'b1};
        tick;
        pkt_valid = 1'b0;
        cmp("fwd_valid", 1'b1, fwd_valid);
        cmp("fwd_mask", em, fwd_mask);
        cmp("fwd_vid", ev, fwd_vid);
        cmp("fwd_mirror", emir, fwd_mirror);
    endtask : pkt

    // drop is combinational, so it is looked at mid-cycle
    task automatic blk(input logic [2:0] p, input logic ed);
        tick;
        {bcast_blk_port, bcast_blk_valid} = {p, 1'b1};
        #40;
        cmp($sformatf("drop port %0d", p), ed, bcast_blk_drop);
        tick;
        bcast_blk_valid = 1'b0;
    endtask : blk

    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        do_reset(1'b1, 1'b0, 1'b1);
        cmp("link", 4'h3, link_bits());
        foreach (ra[i]) rd(ra[i], re[i]);
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h00);
        wr(8'h09, 8'h00);
        rd(8'h09, 8'h4c);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h13);
        wr(8'h06, 8'hf0);
        cmp("link", 4'hf, link_bits());
        rd(8'h06, 8'hf0);
        wr(8'h06, 8'h80);
        cmp("link", 4'h8, link_bits());
        wr(8'h05, 8'h00);
        tx(3'h3, 1'b0);
        wr(8'h05, 8'h10);
        tx(3'h3, 1'b1);
        tx(3'h4, 1'b1);
        pkt(3'h0, 5'h02, 12'h00a, 1'b0, 5'h02, 12'h00a, 1'b1);
        pkt(3'h1, 5'h04, 12'h000, 1'b0, 5'h04, 12'h000, 1'b1);
        pkt(3'h1, 5'h02, 12'h005, 1'b0, 5'h02, 12'h005, 1'b0);
        wr(8'h05, 8'h13);
        wr(8'h06, 8'h08);
        pkt(3'h0, 5'h02, 12'h3e5, 1'b0, 5'h05, 12'h3e5, 1'b0);
        pkt(3'h0, 5'h04, 12'h000, 1'b0, 5'h00, 12'habc, 1'b1);
        pkt(3'h0, 5'h06, 12'h011, 1'b1, 5'h06, 12'h011, 1'b1);
        do_reset(1'b0, 1'b1, 1'b0);
        cmp("link", 4'h4, link_bits());
        wr(8'h07, 8'h02);
        blk(3'h0, 1'b0);
        blk(3'h0, 1'b0);
        blk(3'h0, 1'b1);
        blk(3'h1, 1'b0);
        blk(3'h1, 1'b0);
        blk(3'h1, 1'b1);
        blk(3'h5, 1'b0);
        repeat (12) tick;
        blk(3'h0, 1'b0);
        blk(3'h1, 1'b1);
        repeat (22) tick;
        blk(3'h1, 1'b0);
        wr(8'h07, 8'h00);
        blk(3'h2, 1'b1);
        wr(8'h06, 8'h01);
        blk(3'h2, 1'b0);
        rd(8'h06, 8'h01);
        give_verdict();
    end
endmodule : tb_switch_global_control_regs
